// [design/cwrc_pkg.sv]
// Constants and types shared by the configuration word reset control block
package cwrc_pkg;
   // Register byte offsets on the AXI4-Lite port
   localparam logic [7:0] ADDR_CFG1 = 8'h00;
   localparam logic [7:0] ADDR_CFG2 = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_DECODE = 8'h10;
   // Reset values
   localparam logic [15:0] CFG1_RESET = 16'hffff;
   localparam logic [15:0] CFG2_RESET = 16'hffff;
   localparam logic [15:0] CFG1_FIXED_ONES = 16'hc000;
   localparam logic [15:0] CFG2_FIXED_ONES = 16'hf8ff;
   // Configuration word one field positions
   localparam int OSC_LSB = 0;
   localparam int WATCHDOG_CONFIG_ENABLE_BIT = 3;
   localparam int POWER_UP_DELAY_ENABLE_N_BIT = 4;
   localparam int MASTER_CLEAR_PIN_SELECT_BIT = 5;
   localparam int CP_BIT = 6;
   localparam int CPD_BIT = 7;
   localparam int BOREN_LSB = 8;
   // Configuration word two field positions
   localparam int BORV_BIT = 8;
   localparam int WRT_LSB = 9;
   // Control register field positions
   localparam int CTRL_SWDT_BIT = 0;
   localparam int CTRL_SBOR_BIT = 1;
   localparam int CTRL_VAR_LSB = 4;
   // Status register field positions
   localparam int ST_POR_BIT = 0;
   localparam int ST_DERASE_BIT = 1;
   localparam int ST_PERASE_BIT = 2;
   localparam int ST_CAUSE_LSB = 4;
   localparam int ST_CORE_BIT = 8;
   localparam int ST_MASTER_CLEAR_PIN_BIT = 9;
   // Decode register field positions
   localparam int DEC_WREN_BIT = 9;
   localparam int DEC_LIMIT_LSB = 16;
   // Memory size variants
   localparam logic [1:0] VAR_2K = 2'h0;
   localparam logic [1:0] VAR_4K = 2'h1;
   localparam logic [1:0] VAR_8K = 2'h2;
   // Oscillator modes
   typedef enum logic [2:0] {
      OSC_LP = 3'h0, OSC_XT = 3'h1, OSC_HS = 3'h2, OSC_EC = 3'h3,
      OSC_INTIO = 3'h4, OSC_INTCLK = 3'h5, OSC_RESISTOR_CAPACITOR_OSC_IO = 3'h6, OSC_RCCLK = 3'h7
   } cwrc_osc_t;
   // Reset causes
   typedef enum logic [2:0] {
      CAUSE_NONE = 3'h0, CAUSE_POR = 3'h1, CAUSE_WDT_RUN = 3'h2, CAUSE_WDT_SLEEP = 3'h3,
      CAUSE_MASTER_CLEAR_PIN_RUN = 3'h4, CAUSE_MASTER_CLEAR_PIN_SLEEP = 3'h5, CAUSE_BOR = 3'h6
   } cwrc_cause_t;
   // Master clear glitch filter
   localparam int CLK_PERIOD_NS = 25;
   localparam int MASTER_CLEAR_PIN_FILTER_NS = 2000;
   localparam logic [7:0] MASTER_CLEAR_PIN_FILT_CYC = 8'((MASTER_CLEAR_PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// [design/cwrc_top.sv]
// Configuration word decode, reset source logic and AXI4-Lite register slave
// Operation
// - Data protect active when word1 bit7 zero
// - Program protect active when word1 bit6 zero
// - Bit5 selects master clear or digital pin
// - Power-up delay enabled when bit4 zero
// - Watchdog on by bit3 or software enable
// - Decode all eight oscillator codes
// - Brown-out enable never enables power-up delay
// - Unprotecting data memory erases data memory
// - Unprotecting program memory erases program memory
// - Master clear stops internal or RC oscillator
// - 4K variant write protect ranges
// - 8K variant write protect ranges
// - 2K variant write protect ranges
// - Word2 bit8 selects brown-out threshold
// - Word2 unimplemented bits read as one
// - Record six distinct reset causes
// - Unaffected registers reset only by power-on
// - Main reset excludes watchdog wake from sleep
// - Filter short pulses on master clear
// - Watchdog reset never drives the pin
// - Weak pull-up while master clear selected
// - Brown-out holds reset while supply low
// - Programmed bits read zero, erased read one
// - Power-on clears flag; software sets it
`timescale 1ns/1ps
`default_nettype none
module cwrc_top import cwrc_pkg::*; (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Detector and core inputs
   input wire logic por_detect,
   input wire logic brownout_low,
   input wire logic watchdog_timeout,
   input wire logic core_sleeping,
   // Master clear pin
   input wire logic master_clear_pin_in,
   output logic master_clear_pin_out,
   output logic master_clear_pin_oe,
   output logic master_clear_pull_up_en,
   output logic pin_digital_in,
   // Reset outputs
   output logic core_reset,
   output logic watchdog_wake,
   // Decoded configuration
   output logic [2:0] oscillator_select,
   output logic osc_disable,
   output logic watchdog_enable,
   output logic power_up_delay_timer_en,
   output logic data_memory_protect,
   output logic program_code_protect,
   output logic brownout_threshold_select,
   output logic self_write_protect_en,
   output logic [12:0] self_write_protect_limit,
   output logic data_erase_req,
   output logic program_erase_req
);

   // Register state
   logic [15:0] cfg1; // Configuration word one
   logic [15:0] cfg2; // Configuration word two
   logic [31:0] ctrl; // Control register
   logic power_on_flag; // Cleared by power-on
   logic data_erased; // Sticky erase done
   logic prog_erased; // Sticky erase done
   logic [2:0] last_cause; // Latest reset cause
   // Bus holding state
   logic aw_hold;
   logic w_hold;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   // Filter state
   logic master_clear_pin_filt; // Filtered pin level
   logic [7:0] filt_cnt; // Stability counter

   // Merge write data by byte lane
   function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Self-write protect range per variant, returns enable and top address
   function automatic logic [13:0] wr_range(input logic [1:0] var_sel, input logic [1:0] code);
      logic [13:0] r;
      r = 14'h0000;
      case (var_sel)
         VAR_2K: begin
            case (code)
               2'h0: r = {1'b1, 13'h03ff};
               2'h1: r = {1'b1, 13'h00ff};
               default: r = 14'h0000;
            endcase
         end
         VAR_4K: begin
            case (code)
               2'h0: r = {1'b1, 13'h07ff};
               2'h1: r = {1'b1, 13'h03ff};
               2'h2: r = {1'b1, 13'h00ff};
               default: r = 14'h0000;
            endcase
         end
         VAR_8K: begin
            case (code)
               2'h0: r = {1'b1, 13'h0fff};
               2'h1: r = {1'b1, 13'h07ff};
               2'h2: r = {1'b1, 13'h00ff};
               default: r = 14'h0000;
            endcase
         end
         default: r = 14'h0000;
      endcase
      return r;
   endfunction

   // Write channel handshakes and commit
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire do_write = aw_hold && w_hold && !s_axi_bvalid;
   wire next_aw_hold = (aw_hold || aw_take) && !do_write;
   wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
   wire next_w_hold = (w_hold || w_take) && !do_write;
   // Write address decode
   wire wr_cfg1 = do_write && (awaddr_q == ADDR_CFG1);
   wire wr_cfg2 = do_write && (awaddr_q == ADDR_CFG2);
   wire wr_ctrl = do_write && (awaddr_q == ADDR_CTRL);
   wire wr_stat = do_write && (awaddr_q == ADDR_STATUS);
   wire wr_ok = (awaddr_q == ADDR_CFG1) || (awaddr_q == ADDR_CFG2) ||
                (awaddr_q == ADDR_CTRL) || (awaddr_q == ADDR_STATUS) ||
                (awaddr_q == ADDR_DECODE);
   // Candidate register values, unimplemented configuration word bits forced to one
   wire [31:0] cfg1_merged = apply_strb({16'h0000, cfg1}, wdata_q, wstrb_q);
   wire [31:0] cfg2_merged = apply_strb({16'h0000, cfg2}, wdata_q, wstrb_q);
   wire [15:0] next_cfg1 = cfg1_merged[15:0] | CFG1_FIXED_ONES;
   wire [15:0] next_cfg2 = cfg2_merged[15:0] | CFG2_FIXED_ONES;
   wire [31:0] next_ctrl = apply_strb(ctrl, wdata_q, wstrb_q);
   wire st_lane0 = wstrb_q[0];
   // Protection turned off by a write
   wire data_unprotect = wr_cfg1 && !cfg1[CPD_BIT] && next_cfg1[CPD_BIT];
   wire prog_unprotect = wr_cfg1 && !cfg1[CP_BIT] && next_cfg1[CP_BIT];

   // Configuration decode
   wire [1:0] boren = cfg1[BOREN_LSB +: 2];
   wire bor_enabled = (boren == 2'h3) || ((boren == 2'h2) && !core_sleeping) ||
                      ((boren == 2'h1) && ctrl[CTRL_SBOR_BIT]);
   wire [13:0] wr_dec = wr_range(ctrl[CTRL_VAR_LSB +: 2], cfg2[WRT_LSB +: 2]);
   wire master_clear_pin_sel = cfg1[MASTER_CLEAR_PIN_SELECT_BIT];
   wire master_clear_pin_active = master_clear_pin_sel && !master_clear_pin_filt;
   wire bor_active = bor_enabled && brownout_low;
   wire wdt_run_rst = watchdog_enable && watchdog_timeout && !core_sleeping;
   wire wdt_sleep_wake = watchdog_enable && watchdog_timeout && core_sleeping;
   wire reset_hold = por_detect || bor_active || master_clear_pin_active || wdt_run_rst;
   wire osc_rc_or_int = cfg1[OSC_LSB + 2]; // Codes 1xx: RC or internal

   // Cause selection, power-on first
   cwrc_cause_t next_cause;
   assign next_cause = por_detect ? CAUSE_POR :
                       bor_active ? CAUSE_BOR :
                       (master_clear_pin_active && core_sleeping) ? CAUSE_MASTER_CLEAR_PIN_SLEEP :
                       master_clear_pin_active ? CAUSE_MASTER_CLEAR_PIN_RUN :
                       wdt_run_rst ? CAUSE_WDT_RUN :
                       wdt_sleep_wake ? CAUSE_WDT_SLEEP : cwrc_cause_t'(last_cause);

   // Read decode
   wire [31:0] st_word = {22'h000000, master_clear_pin_filt, core_reset, 1'b0, last_cause, 1'b0,
                          prog_erased, data_erased, power_on_flag};
   wire [31:0] dec_word = {3'h0, self_write_protect_limit, 6'h00, self_write_protect_en,
                           brownout_threshold_select, osc_disable, program_code_protect,
                           data_memory_protect, power_up_delay_timer_en, watchdog_enable,
                           oscillator_select};
   wire rd_ok = (s_axi_araddr == ADDR_CFG1) || (s_axi_araddr == ADDR_CFG2) ||
                (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_STATUS) ||
                (s_axi_araddr == ADDR_DECODE);
   wire [31:0] rd_data = (s_axi_araddr == ADDR_CFG1) ? {16'h0000, cfg1} :
                         (s_axi_araddr == ADDR_CFG2) ? {16'h0000, cfg2} :
                         (s_axi_araddr == ADDR_CTRL) ? ctrl :
                         (s_axi_araddr == ADDR_STATUS) ? st_word :
                         (s_axi_araddr == ADDR_DECODE) ? dec_word : 32'h00000000;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

   // Write channel registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (clk_en) begin
         aw_hold <= next_aw_hold;
         w_hold <= next_w_hold;
         // Capture address and data when taken
         if (aw_take) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         s_axi_awready <= !next_aw_hold && !next_bvalid;
         s_axi_wready <= !next_w_hold && !next_bvalid;
         s_axi_bvalid <= next_bvalid;
         // OKAY or SLVERR for unmapped
         if (do_write) begin
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
         end
      end
   end

   // Read channel registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (clk_en) begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_take) begin
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
         end
      end
   end

   // Software registers; configuration writes model programming
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg1 <= CFG1_RESET;
         cfg2 <= CFG2_RESET;
         ctrl <= 32'h00000000;
      end else if (clk_en) begin
         if (wr_cfg1) begin
            cfg1 <= next_cfg1;
         end
         if (wr_cfg2) begin
            cfg2 <= next_cfg2;
         end
         if (wr_ctrl) begin
            ctrl <= next_ctrl & 32'h00000033;
         end
      end
   end

   // Status flags; hardware set or clear beats software write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         power_on_flag <= 1'b0;
         data_erased <= 1'b0;
         prog_erased <= 1'b0;
         last_cause <= CAUSE_POR;
      end else if (clk_en) begin
         // Power-on clears, software writes one to set
         if (por_detect) begin
            power_on_flag <= 1'b0;
         end else if (wr_stat && st_lane0 && wdata_q[ST_POR_BIT]) begin
            power_on_flag <= 1'b1;
         end
         // Erase done flags, write one to clear
         data_erased <= data_unprotect ||
                        (data_erased && !(wr_stat && st_lane0 && wdata_q[ST_DERASE_BIT]));
         prog_erased <= prog_unprotect ||
                        (prog_erased && !(wr_stat && st_lane0 && wdata_q[ST_PERASE_BIT]));
         last_cause <= next_cause;
      end
   end

   // Master clear glitch filter: level must hold for the filter time
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         master_clear_pin_filt <= 1'b1;
         filt_cnt <= 8'h00;
      end else if (clk_en) begin
         if (master_clear_pin_in == master_clear_pin_filt) begin
            filt_cnt <= 8'h00;
         end else if (filt_cnt == MASTER_CLEAR_PIN_FILT_CYC - 8'h01) begin
            master_clear_pin_filt <= master_clear_pin_in;
            filt_cnt <= 8'h00;
         end else begin
            filt_cnt <= filt_cnt + 8'h01;
         end
      end
   end

   // Reset outputs; core_reset resets no register, all storage resets only on rst_n
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         core_reset <= 1'b1;
         watchdog_wake <= 1'b0;
      end else if (clk_en) begin
         core_reset <= reset_hold;
         watchdog_wake <= wdt_sleep_wake && !reset_hold;
      end
   end

   // Pin control and decoded configuration outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         master_clear_pin_out <= 1'b0;
         master_clear_pin_oe <= 1'b0;
         master_clear_pull_up_en <= 1'b1;
         pin_digital_in <= 1'b0;
         oscillator_select <= OSC_RCCLK;
         osc_disable <= 1'b0;
         watchdog_enable <= 1'b1;
         power_up_delay_timer_en <= 1'b0;
         data_memory_protect <= 1'b0;
         program_code_protect <= 1'b0;
         brownout_threshold_select <= 1'b1;
         self_write_protect_en <= 1'b0;
         self_write_protect_limit <= 13'h0000;
         data_erase_req <= 1'b0;
         program_erase_req <= 1'b0;
      end else if (clk_en) begin
         master_clear_pin_out <= 1'b0;
         master_clear_pin_oe <= 1'b0;
         master_clear_pull_up_en <= master_clear_pin_sel;
         pin_digital_in <= master_clear_pin_sel ? 1'b0 : master_clear_pin_in;
         oscillator_select <= cfg1[OSC_LSB +: 3];
         osc_disable <= master_clear_pin_active && osc_rc_or_int;
         watchdog_enable <= cfg1[WATCHDOG_CONFIG_ENABLE_BIT] || ctrl[CTRL_SWDT_BIT];
         power_up_delay_timer_en <= !cfg1[POWER_UP_DELAY_ENABLE_N_BIT];
         data_memory_protect <= !cfg1[CPD_BIT];
         program_code_protect <= !cfg1[CP_BIT];
         brownout_threshold_select <= cfg2[BORV_BIT];
         self_write_protect_en <= wr_dec[13];
         self_write_protect_limit <= wr_dec[12:0];
         data_erase_req <= data_unprotect;
         program_erase_req <= prog_unprotect;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_sleep_timeout;
      clk_en && watchdog_enable && watchdog_timeout && core_sleeping && !reset_hold;
   endsequence
   sequence s_wake_no_reset;
      watchdog_wake && !core_reset;
   endsequence

   property p_data_protect;
      clk_en |=> (data_memory_protect == !$past(cfg1[CPD_BIT]));
   endproperty
   a_data_protect: assert property (p_data_protect) else $error("data protect wrong");
   property p_prog_protect;
      clk_en |=> (program_code_protect == !$past(cfg1[CP_BIT]));
   endproperty
   a_prog_protect: assert property (p_prog_protect) else $error("program protect wrong");
   property p_master_clear_pin_off;
      (clk_en && !master_clear_pin_sel) |=> !core_reset || $past(por_detect || bor_active || wdt_run_rst);
   endproperty
   a_master_clear_pin_off: assert property (p_master_clear_pin_off) else $error("master clear not ignored");
   property p_power_up_delay_timer;
      clk_en |=> (power_up_delay_timer_en == !$past(cfg1[POWER_UP_DELAY_ENABLE_N_BIT]));
   endproperty
   a_power_up_delay_timer: assert property (p_power_up_delay_timer) else $error("power-up delay enable wrong");
   property p_wdt_en;
      clk_en |=> (watchdog_enable == ($past(cfg1[WATCHDOG_CONFIG_ENABLE_BIT]) || $past(ctrl[CTRL_SWDT_BIT])));
   endproperty
   a_wdt_en: assert property (p_wdt_en) else $error("watchdog enable wrong");
   property p_erase;
      data_erase_req |-> $past(cfg1[CPD_BIT]) == 1'b0 && cfg1[CPD_BIT];
   endproperty
   a_erase: assert property (p_erase) else $error("erase without unprotect");
   property p_osc_stop;
      (clk_en && master_clear_pin_active && cfg1[OSC_LSB + 2]) |=> osc_disable && core_reset;
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("oscillator not stopped");
   property p_wake;
      s_sleep_timeout |=> s_wake_no_reset;
   endproperty
   a_wake: assert property (p_wake) else $error("watchdog wake reset core");
   property p_filter;
      $changed(master_clear_pin_filt) |-> $past(filt_cnt) == MASTER_CLEAR_PIN_FILT_CYC - 8'h01;
   endproperty
   a_filter: assert property (p_filter) else $error("filter changed early");
   property p_pin_quiet;
      !master_clear_pin_oe;
   endproperty
   a_pin_quiet: assert property (p_pin_quiet) else $error("pin driven");
   property p_bor_hold;
      (clk_en && bor_active) |=> core_reset;
   endproperty
   a_bor_hold: assert property (p_bor_hold) else $error("brown-out not held");
   property p_por_flag;
      (clk_en && por_detect) |=> !power_on_flag && (last_cause == CAUSE_POR);
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("power-on flag not cleared");
endmodule
`default_nettype wire

// [tb/cwrc_board.sv]
// Board model: supply detectors and external reset pin driver
`timescale 1ns/1ps
`default_nettype none
module cwrc_board (
   // Clock
   input wire logic clk_sys,
   // Bench controls
   input wire logic drv_en,
   input wire logic drv_lvl,
   input wire logic supply_low,
   // Device pin side
   input wire logic master_clear_pin_oe,
   input wire logic master_clear_pin_out,
   input wire logic master_clear_pull_up_en,
   output logic master_clear_pin_in,
   // Detectors
   output logic por_detect,
   output logic brownout_low
);
   logic [5:0] ramp = 6'h00; // Supply ramp counter
   logic flt = 1'b0; // Pattern of an undriven pin
   // Ramp counts up once, floating level toggles
   always_ff @(posedge clk_sys) begin
      if (ramp != 6'h18) ramp <= ramp + 6'h01;
      flt <= ~flt;
   end
   assign por_detect = (ramp != 6'h18); // High while supply ramps
   assign brownout_low = supply_low; // Supply below threshold
   // Wire: device, board driver, pull-up, else floating
   assign master_clear_pin_in = master_clear_pin_oe ? master_clear_pin_out :
      drv_en ? drv_lvl : master_clear_pull_up_en ? 1'b1 : flt;
endmodule
`default_nettype wire

// [tb/config_word_reset_control_tb.sv]
// Testbench for the configuration word reset control block
`timescale 1ns/1ps
`default_nettype none
module config_word_reset_control_tb import cwrc_pkg::*;;
   logic clk_sys = 1'b0, rst_n = 1'b0, drv_en = 1'b0, drv_lvl = 1'b1, supply_low = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, watchdog_timeout = 0, core_sleeping = 0, hit;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic por_detect, brownout_low, master_clear_pin_in, master_clear_pin_out, core_reset;
   logic master_clear_pin_oe, master_clear_pull_up_en, pin_digital_in, watchdog_wake;
   logic osc_disable, watchdog_enable, power_up_delay_timer_en, data_memory_protect;
   logic program_code_protect, brownout_threshold_select, self_write_protect_en;
   logic [2:0] oscillator_select;
   logic [12:0] self_write_protect_limit;
   int err_count = 0, compares = 0;
   // Device and board
   cwrc_top i_dut (.*, .clk_en(1'b1), .s_axi_wstrb(4'hf), .data_erase_req(),
      .program_erase_req());
   cwrc_board i_board (.*);
   // Compare one value
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", w, e, g);
      end
   endtask
   // Bus write, address and data offered together
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   // Bus read, masked compare
   task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] m, e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rsp = s_axi_rresp;
      rdv = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk(w, e, rdv & m);
   endtask
   // Wait n cycles, noting any core reset
   task automatic watch(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         hit = hit | core_reset;
      end
   endtask
   // Reset values, power flag, unmapped place
   task automatic t_reset;
      rdc("word1", ADDR_CFG1, 32'hffff, 32'hffff);
      rdc("word2", ADDR_CFG2, 32'hffff, 32'hffff);
      rdc("status", ADDR_STATUS, 32'h71, 32'h10);
      axw(ADDR_STATUS, 32'h1);
      rdc("flag", ADDR_STATUS, 32'h1, 32'h1);
      axw(8'h40, 32'h0);
      chk("bresp", 32'h2, 32'(rsp));
      rdc("unmapped", 8'h40, 32'hffffffff, 32'h0);
      chk("rresp", 32'h2, 32'(rsp));
      $display("test reset done");
   endtask
   // Word one decode and erase on unprotect
   task automatic t_word1;
      for (int i = 0; i < 8; i++) begin
         axw(ADDR_CFG1, 32'hfff8 | 32'(i));
         chk("osc", 32'(i), 32'(oscillator_select));
      end
      drv_en <= 1'b1;
      drv_lvl <= 1'b0;
      axw(ADDR_CFG1, 32'h0);
      rdc("word1", ADDR_CFG1, 32'hffff, 32'hc000);
      chk("dprot", 32'h1, 32'(data_memory_protect));
      chk("pprot", 32'h1, 32'(program_code_protect));
      chk("delay", 32'h1, 32'(power_up_delay_timer_en));
      chk("wdt", 32'h0, 32'(watchdog_enable));
      chk("pullup", 32'h0, 32'(master_clear_pull_up_en));
      hit = 1'b0;
      watch(100);
      chk("pin rst", 32'h0, 32'(hit));
      chk("pin dig", 32'h0, 32'(pin_digital_in));
      drv_lvl <= 1'b1;
      axw(ADDR_CTRL, 32'h1);
      chk("pin dig", 32'h1, 32'(pin_digital_in));
      chk("sw wdt", 32'h1, 32'(watchdog_enable));
      axw(ADDR_CTRL, 32'h0);
      axw(ADDR_CFG1, 32'hffff);
      drv_en <= 1'b0;
      chk("dprot", 32'h0, 32'(data_memory_protect));
      chk("pprot", 32'h0, 32'(program_code_protect));
      chk("delay", 32'h0, 32'(power_up_delay_timer_en));
      chk("pullup", 32'h1, 32'(master_clear_pull_up_en));
      rdc("erased", ADDR_STATUS, 32'h6, 32'h6);
      $display("test word1 done");
   endtask
   // Write protect ranges per size and threshold
   task automatic t_wp;
      logic [12:0] lim [3][4] = '{'{13'h3ff, 13'h0ff, 13'h0, 13'h0},
         '{13'h7ff, 13'h3ff, 13'h0ff, 13'h0}, '{13'hfff, 13'h7ff, 13'h0ff, 13'h0}};
      for (int v = 0; v < 3; v++) begin
         for (int c = 0; c < 4; c++) begin
            axw(ADDR_CTRL, 32'(v) << 4);
            axw(ADDR_CFG2, 32'hf9ff | (32'(c) << 9));
            chk("wp en", 32'(lim[v][c] != 0), 32'(self_write_protect_en));
            if (lim[v][c] != 0) chk("wp lim", 32'(lim[v][c]), 32'(self_write_protect_limit));
            chk("thr", 32'h1, 32'(brownout_threshold_select));
         end
      end
      axw(ADDR_CFG2, 32'h0);
      chk("thr", 32'h0, 32'(brownout_threshold_select));
      rdc("word2", ADDR_CFG2, 32'hffff, 32'hf8ff);
      $display("test write protect done");
   endtask
   // Master clear filter, run and sleep causes
   task automatic t_master_clear_pin;
      drv_en <= 1'b1;
      drv_lvl <= 1'b0;
      hit = 1'b0;
      watch(40);
      drv_lvl <= 1'b1;
      watch(100);
      chk("glitch", 32'h0, 32'(hit));
      drv_lvl <= 1'b0;
      repeat (100) @(posedge clk_sys);
      chk("master_clear_pin rst", 32'h1, 32'(core_reset));
      chk("osc off", 32'h1, 32'(osc_disable));
      drv_lvl <= 1'b1;
      repeat (100) @(posedge clk_sys);
      rdc("cause", ADDR_STATUS, 32'h70, 32'h40);
      core_sleeping <= 1'b1;
      drv_lvl <= 1'b0;
      repeat (100) @(posedge clk_sys);
      drv_lvl <= 1'b1;
      repeat (100) @(posedge clk_sys);
      core_sleeping <= 1'b0;
      drv_en <= 1'b0;
      rdc("cause", ADDR_STATUS, 32'h70, 32'h50);
      $display("test master clear done");
   endtask
   // Watchdog in sleep wakes, in run resets
   task automatic t_wdt;
      core_sleeping <= 1'b1;
      watchdog_timeout <= 1'b1;
      @(posedge clk_sys);
      watchdog_timeout <= 1'b0;
      hit = 1'b0;
      @(posedge clk_sys);
      chk("wake", 32'h1, 32'(watchdog_wake));
      watch(5);
      chk("wake rst", 32'h0, 32'(hit));
      rdc("cause", ADDR_STATUS, 32'h70, 32'h30);
      core_sleeping <= 1'b0;
      watchdog_timeout <= 1'b1;
      @(posedge clk_sys);
      watchdog_timeout <= 1'b0;
      watch(4);
      chk("wdt rst", 32'h1, 32'(hit));
      chk("pin oe", 32'h0, 32'(master_clear_pin_oe));
      repeat (5) @(posedge clk_sys);
      rdc("cause", ADDR_STATUS, 32'h70, 32'h20);
      $display("test watchdog done");
   endtask
   // Brown-out holds reset while supply is low
   task automatic t_bor;
      supply_low <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk("bor rst", 32'h1, 32'(core_reset));
      supply_low <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk("bor rel", 32'h0, 32'(core_reset));
      rdc("cause", ADDR_STATUS, 32'h71, 32'h61);
      $display("test brown-out done");
   endtask
   // Counts, verdict and stop
   task automatic end_of_test;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Clock
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Hang guard
   initial begin
      #500us;
      err_count++;
      end_of_test();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (30) @(posedge clk_sys);
      t_reset();
      t_word1();
      t_wp();
      t_master_clear_pin();
      t_wdt();
      t_bor();
      end_of_test();
   end
endmodule
`default_nettype wire
